//--- include/phy_an_regs_cfg.svh
// Operation
// RULE_01: Expansion bit 6 is read-only one: storage place told by bit 5.
// RULE_02: Expansion bit 5 reads one: partner next pages go to index 8.
// RULE_03: Expansion bit 4 latches high on a parallel detection fault.
// RULE_04: Expansion bit 3 read-only, reset zero, partner next page able.
// RULE_05: Expansion bit 2 reads one: local PHY supports next pages.
// RULE_06: Expansion bit 1 latches high when a new page is received.
// RULE_07: Expansion bit 0 read-only, reset zero, partner autoneg able.
// RULE_08: Transmit next page bits 15, 13, 12 writable, resets 0, 1, 0.
// RULE_09: Transmit toggle bit 11 read-only, inverse of last sent toggle.
// RULE_10: Transmit register at index 7, code field 10:0 resets to one.
// RULE_11: Receive bit 14 reads one once a link code word arrived; the code copies bit 14 from i_an.page_word as received.
// RULE_12: Receive register at index 8 is read-only, all fields reset zero.
// RULE_13: Function 00 is address mode, 01 is data; 10 and 11 unused.
// RULE_14: Access control bits 4:0 hold target device, reset zero.
// RULE_15: In address mode a write to address/data sets MMD address.
// RULE_16: In data mode address/data reaches the latched MMD address.
// RULE_17: Latched-high bits clear on read and set again while present.
// RULE_18: Host sets address first, then data mode with the same device.
`ifndef PHY_AN_REGS_CFG_SVH
`define PHY_AN_REGS_CFG_SVH

// Register indexes; byte address is four times the index
`define IDX_AN_EXPANSION 4'h6
`define IDX_NP_TRANSMIT 4'h7
`define IDX_NP_RECEIVE 4'h8
`define IDX_ACCESS_CTRL 4'hd
`define IDX_ADDR_DATA 4'he

// Expansion field positions
`define EXP_LOC_ABLE_BIT 6
`define EXP_LOC_BIT 5
`define EXP_PD_FAULT_BIT 4
`define EXP_LP_NP_ABLE_BIT 3
`define EXP_NP_ABLE_BIT 2
`define EXP_PAGE_RX_BIT 1
`define EXP_LP_AN_ABLE_BIT 0

// Next page field positions
`define NP_NEXT_BIT 15
`define NP_ACK_BIT 14
`define NP_MSG_BIT 13
`define NP_ACK2_BIT 12
`define NP_TOGGLE_BIT 11

// Reset values
`define NP_TX_RESET 16'h2001
`define NP_RX_RESET 16'h0000
`define ADDR_DATA_RESET 16'h0000

// Indirect function codes
`define MMD_FN_ADDRESS 2'h0
`define MMD_FN_DATA 2'h1

`endif

//--- include/phy_an_regs_pkg.sv
package phy_an_regs_pkg;

    // Page exchange events from the autoneg engine
    typedef struct packed {
        logic page_rx;
        logic [15:0] page_word;
        logic page_sent;
        logic sent_toggle;
        logic pd_fault;
        logic lp_an_able;
        logic lp_np_able;
    } an_event_t;

    // Indirect MMD access request towards the MMD register space
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] dev;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mmd_req_t;

    // Transfer state of the APB slave
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MMD_WAIT = 3'b010,
        ST_DONE = 3'b100
    } apb_state_t;

endpackage

//--- hdl/phy_an_regs.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "phy_an_regs_cfg.svh"

module phy_an_regs #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Autoneg engine
    input wire phy_an_regs_pkg::an_event_t i_an,
    output logic [15:0] o_np_tx_word,
    // MMD register space
    output phy_an_regs_pkg::mmd_req_t o_mmd_req,
    input wire logic i_mmd_ack,
    input wire logic [15:0] i_mmd_rdata
);

    // The index decode reads address bits 5:2, so narrower buses cannot reach the map
    if (ADDR_W < 6) begin
        $error("ADDR_W too small for the register map");
    end
    if (ADDR_W > 32) begin
        $error("ADDR_W wider than the bus address");
    end

    // Transfer state
    phy_an_regs_pkg::apb_state_t state_r;

    // Status seen through the expansion register
    logic pd_fault_r;
    logic page_rx_r;
    logic lp_np_able_r;
    logic lp_an_able_r;
    logic pd_fault_nxt;
    logic page_rx_nxt;

    // Next page words
    logic [15:0] np_tx_r;
    logic [15:0] np_rx_r;

    // Indirect access state
    logic [1:0] mmd_fn_r;
    logic [4:0] mmd_dev_r;
    logic [15:0] mmd_addr_r;
    logic [15:0] mmd_data_r;

    // Decode of the current transfer
    logic [3:0] idx;
    logic mapped;
    logic setup;
    logic wr_take;
    logic rd_take;
    logic is_data_mode;
    logic exp_read_done;

    // Read path
    logic [15:0] exp_word;
    logic [15:0] rd_word;

    // Register index from the word address
    function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
        return a[5:2];
    endfunction

    // Register is mapped when its index is one of the five and all other address bits are zero
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = (a[1:0] == 2'h0) && ((a >> 6) == '0);
        case (a[5:2])
            `IDX_AN_EXPANSION, `IDX_NP_TRANSMIT, `IDX_NP_RECEIVE,
            `IDX_ACCESS_CTRL, `IDX_ADDR_DATA: is_mapped = hit;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // Completed transfer that addresses one register
    function automatic logic index_hit(input logic take, input logic [3:0] at, input logic [3:0] want);
        return take && (at == want);
    endfunction

    assign idx = reg_index(i_paddr);
    assign mapped = is_mapped(i_paddr);
    assign setup = i_psel && !i_penable;
    assign is_data_mode = (mmd_fn_r == `MMD_FN_DATA); // [RULE_13]

    // Data mode on the address/data register needs the MMD space to answer
    logic mmd_access;
    assign mmd_access = mapped && (idx == `IDX_ADDR_DATA) && is_data_mode;

    // Access phase completes on the cycle pready is high
    assign wr_take = i_psel && i_penable && o_pready && i_pwrite && mapped;
    assign rd_take = i_psel && i_penable && o_pready && !i_pwrite && mapped;

    // Ready: immediately for local registers, after the MMD ack otherwise
    always_comb begin
        case (state_r)
            phy_an_regs_pkg::ST_IDLE: o_pready = 1'b0;
            phy_an_regs_pkg::ST_MMD_WAIT: o_pready = 1'b0;
            phy_an_regs_pkg::ST_DONE: o_pready = i_psel && i_penable;
            default: o_pready = 1'b0;
        endcase
    end
    assign o_pslverr = o_pready && !mapped;

    // Slave state: setup cycle decides the path, ready comes one or more cycles later
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            state_r <= phy_an_regs_pkg::ST_IDLE;
        end else begin
            case (state_r)
                phy_an_regs_pkg::ST_IDLE: begin
                    if (setup && mmd_access) begin
                        state_r <= phy_an_regs_pkg::ST_MMD_WAIT;
                    end else if (setup) begin
                        state_r <= phy_an_regs_pkg::ST_DONE;
                    end
                end
                phy_an_regs_pkg::ST_MMD_WAIT: begin
                    if (i_mmd_ack) begin
                        state_r <= phy_an_regs_pkg::ST_DONE;
                    end
                end
                phy_an_regs_pkg::ST_DONE: begin
                    if (o_pready) begin
                        state_r <= phy_an_regs_pkg::ST_IDLE;
                    end
                end
                default: state_r <= phy_an_regs_pkg::ST_IDLE;
            endcase
        end
    end

    // MMD request strobes: one pulse on entry to the wait state
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_mmd_req <= '0;
        end else begin
            o_mmd_req.wr <= 1'b0;
            o_mmd_req.rd <= 1'b0;
            if (state_r == phy_an_regs_pkg::ST_IDLE && setup && mmd_access) begin
                o_mmd_req.wr <= i_pwrite; // [RULE_16]
                o_mmd_req.rd <= !i_pwrite; // [RULE_16]
                o_mmd_req.dev <= mmd_dev_r; // [RULE_14]
                o_mmd_req.addr <= mmd_addr_r; // [RULE_16]
                o_mmd_req.wdata <= i_pwdata[15:0];
            end
        end
    end

    // Latched MMD read data, or the written data on a write, shown through the address/data register
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            mmd_data_r <= `ADDR_DATA_RESET;
        end else if (state_r == phy_an_regs_pkg::ST_MMD_WAIT && i_mmd_ack) begin
            mmd_data_r <= i_pwrite ? o_mmd_req.wdata : i_mmd_rdata; // [RULE_16]
        end
    end

    // Function code; reserved codes are stored but never reach the MMD space
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            mmd_fn_r <= `MMD_FN_ADDRESS;
        end else if (index_hit(wr_take, idx, `IDX_ACCESS_CTRL) && i_pstrb[1]) begin
            mmd_fn_r <= i_pwdata[15:14]; // [RULE_13]
        end
    end

    // Target device of the indirect access
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            mmd_dev_r <= 5'h00;
        end else if (index_hit(wr_take, idx, `IDX_ACCESS_CTRL) && i_pstrb[0]) begin
            mmd_dev_r <= i_pwdata[4:0]; // [RULE_14]
        end
    end

    // MMD address is set only in address mode
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            mmd_addr_r <= `ADDR_DATA_RESET;
        end else if (wr_take && idx == `IDX_ADDR_DATA && mmd_fn_r == `MMD_FN_ADDRESS) begin
            if (i_pstrb[0]) begin
                mmd_addr_r[7:0] <= i_pwdata[7:0]; // [RULE_15]
            end
            if (i_pstrb[1]) begin
                mmd_addr_r[15:8] <= i_pwdata[15:8]; // [RULE_15]
            end
        end
    end

    // Next page transmit: writable fields, toggle from the engine
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            np_tx_r <= `NP_TX_RESET; // [RULE_08] [RULE_10]
        end else begin
            if (wr_take && idx == `IDX_NP_TRANSMIT) begin
                if (i_pstrb[0]) begin
                    np_tx_r[7:0] <= i_pwdata[7:0]; // [RULE_10]
                end
                if (i_pstrb[1]) begin
                    np_tx_r[10:8] <= i_pwdata[10:8]; // [RULE_10]
                    np_tx_r[`NP_NEXT_BIT] <= i_pwdata[`NP_NEXT_BIT]; // [RULE_08]
                    np_tx_r[`NP_MSG_BIT] <= i_pwdata[`NP_MSG_BIT]; // [RULE_08]
                    np_tx_r[`NP_ACK2_BIT] <= i_pwdata[`NP_ACK2_BIT]; // [RULE_08]
                end
            end
            // Toggle is not writable; it follows what the engine sent
            if (i_an.page_sent) begin
                np_tx_r[`NP_TOGGLE_BIT] <= !i_an.sent_toggle; // [RULE_09]
            end
            np_tx_r[14] <= 1'b0;
        end
    end
    assign o_np_tx_word = np_tx_r;

    // Next page receive: whole code word captured on a new page
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            np_rx_r <= `NP_RX_RESET; // [RULE_12]
        end else if (i_an.page_rx) begin
            np_rx_r <= i_an.page_word; // [RULE_02] [RULE_11] [RULE_12]
        end
    end

    // Partner next page ability level
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            lp_np_able_r <= 1'b0;
        end else begin
            lp_np_able_r <= i_an.lp_np_able; // [RULE_04]
        end
    end

    // Partner autoneg ability level
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            lp_an_able_r <= 1'b0;
        end else begin
            lp_an_able_r <= i_an.lp_an_able; // [RULE_07]
        end
    end

    // Read data was captured at setup, so a flag set since then must survive the clear
    assign exp_read_done = index_hit(rd_take, idx, `IDX_AN_EXPANSION);

    // Next values of the latched flags; a new event wins over the clear
    always_comb begin
        pd_fault_nxt = pd_fault_r;
        page_rx_nxt = page_rx_r;
        if (exp_read_done && o_prdata[`EXP_PD_FAULT_BIT]) begin
            pd_fault_nxt = 1'b0; // [RULE_17]
        end
        if (exp_read_done && o_prdata[`EXP_PAGE_RX_BIT]) begin
            page_rx_nxt = 1'b0; // [RULE_17]
        end
        if (i_an.pd_fault) begin
            pd_fault_nxt = 1'b1; // [RULE_03]
        end
        if (i_an.page_rx) begin
            page_rx_nxt = 1'b1; // [RULE_06]
        end
    end

    // Parallel detection fault flag
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            pd_fault_r <= 1'b0;
        end else begin
            pd_fault_r <= pd_fault_nxt; // [RULE_03] [RULE_17]
        end
    end

    // Page received flag
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            page_rx_r <= 1'b0;
        end else begin
            page_rx_r <= page_rx_nxt; // [RULE_06] [RULE_17]
        end
    end

    // Expansion word; constant ability bits are wired in
    always_comb begin
        exp_word = 16'h0000;
        exp_word[`EXP_LOC_ABLE_BIT] = 1'b1; // [RULE_01]
        exp_word[`EXP_LOC_BIT] = 1'b1; // [RULE_02]
        exp_word[`EXP_PD_FAULT_BIT] = pd_fault_r; // [RULE_03]
        exp_word[`EXP_LP_NP_ABLE_BIT] = lp_np_able_r; // [RULE_04]
        exp_word[`EXP_NP_ABLE_BIT] = 1'b1; // [RULE_05]
        exp_word[`EXP_PAGE_RX_BIT] = page_rx_r; // [RULE_06]
        exp_word[`EXP_LP_AN_ABLE_BIT] = lp_an_able_r; // [RULE_07]
    end

    // Read mux; reserved bits and unmapped indexes read zero
    always_comb begin
        case (idx)
            `IDX_AN_EXPANSION: rd_word = exp_word;
            `IDX_NP_TRANSMIT: rd_word = np_tx_r;
            `IDX_NP_RECEIVE: rd_word = np_rx_r;
            `IDX_ACCESS_CTRL: rd_word = {mmd_fn_r, 9'h000, mmd_dev_r};
            `IDX_ADDR_DATA: rd_word = is_data_mode ? mmd_data_r : mmd_addr_r; // [RULE_16]
            default: rd_word = 16'h0000;
        endcase
    end

    // Read data registered in the setup cycle, or after MMD completion
    logic [31:0] prdata_r;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            prdata_r <= 32'h0000_0000;
        end else if (state_r == phy_an_regs_pkg::ST_IDLE && setup) begin
            prdata_r <= mapped ? {16'h0000, rd_word} : 32'h0000_0000;
        end else if (state_r == phy_an_regs_pkg::ST_MMD_WAIT && i_mmd_ack && !i_pwrite) begin
            prdata_r <= {16'h0000, i_mmd_rdata}; // [RULE_16]
        end
    end
    assign o_prdata = prdata_r;

endmodule

//--- verif/phy_an_regs_asserts.sv
`timescale 1ns/1ps
module phy_an_regs_asserts #(
    parameter int ADDR_W = 8
) (
    // Watched ports
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire phy_an_regs_pkg::an_event_t i_an,
    input wire logic [15:0] o_np_tx_word,
    input wire phy_an_regs_pkg::mmd_req_t o_mmd_req,
    input wire logic i_mmd_ack
);
    logic done, rd_exp, wr_tx;
    // Completed transfers at the sampling edge
    assign done = i_psel && i_penable && o_pready;
    assign rd_exp = done && !i_pwrite && i_paddr == ADDR_W'(8'h18);
    assign wr_tx = done && i_pwrite && i_paddr == ADDR_W'(8'h1c) && i_pstrb[1:0] == 2'b11;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    property p_tx_reset;
        !$past(i_rstn) |-> o_np_tx_word == 16'h2001;
    endproperty
    a_tx_reset: assert property (p_tx_reset) else $error("tx reset");
    property p_exp_fixed;
        rd_exp |-> o_prdata[15:5] == 11'h003 && o_prdata[2];
    endproperty
    a_exp_fixed: assert property (p_exp_fixed) else $error("fixed bits");
    // Level must be steady over the read, else the flop may hold either value
    property p_exp_lp;
        rd_exp && $stable(i_an.lp_an_able) && $past(i_an.lp_an_able, 2) == i_an.lp_an_able
            |-> o_prdata[0] == i_an.lp_an_able;
    endproperty
    a_exp_lp: assert property (p_exp_lp) else $error("partner able");
    property p_exp_latch;
        rd_exp |-> (o_prdata[1] || !$past(i_an.page_rx, 2)) && (o_prdata[4] || !$past(i_an.pd_fault, 2));
    endproperty
    a_exp_latch: assert property (p_exp_latch) else $error("latch lost");
    property p_tx_write;
        wr_tx |=> o_np_tx_word[15] == $past(i_pwdata[15]) && !o_np_tx_word[14]
            && o_np_tx_word[13:12] == $past(i_pwdata[13:12]) && o_np_tx_word[10:0] == $past(i_pwdata[10:0]);
    endproperty
    a_tx_write: assert property (p_tx_write) else $error("tx write");
    property p_toggle;
        i_an.page_sent |=> o_np_tx_word[11] != $past(i_an.sent_toggle);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle");
    property p_mmd_wr;
        o_mmd_req.wr |-> i_pwrite && i_paddr == ADDR_W'(8'h38) && o_mmd_req.wdata == i_pwdata[15:0] ##1 !o_mmd_req.wr;
    endproperty
    a_mmd_wr: assert property (p_mmd_wr) else $error("mmd write");
    property p_mmd_rd;
        o_mmd_req.rd |-> !i_pwrite && i_paddr == ADDR_W'(8'h38) ##1 !o_mmd_req.rd;
    endproperty
    a_mmd_rd: assert property (p_mmd_rd) else $error("mmd read");
    property p_ack_ready;
        i_mmd_ack |=> o_pready && i_penable;
    endproperty
    a_ack_ready: assert property (p_ack_ready) else $error("ack to ready");
    c_event: cover property (rd_exp && $past(i_an.page_rx, 2));
    c_mmd: cover property (i_mmd_ack);
    c_wr: cover property (wr_tx);
endmodule

bind phy_an_regs phy_an_regs_asserts #(.ADDR_W(ADDR_W)) i_phy_an_regs_asserts (
    .i_sys_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .i_pstrb, .o_prdata, .o_pready, .i_an, .o_np_tx_word, .o_mmd_req, .i_mmd_ack
);

//--- verif/mmd_space_model.sv
`timescale 1ns/1ps
module mmd_space_model (
    // Clock and request
    input wire logic i_sys_clk,
    input wire phy_an_regs_pkg::mmd_req_t i_req,
    input wire logic [3:0] i_lat,
    // Answer
    output logic o_ack,
    output logic [15:0] o_rdata
);
    logic [15:0] mem [logic [20:0]];
    logic [20:0] key;
    // Answers after i_lat cycles; data is junk off the ack cycle
    initial begin
        o_ack = 1'b0;
        o_rdata = 16'h0000;
        forever begin
            @(posedge i_sys_clk);
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
            if (i_req.wr || i_req.rd) begin
                key = {i_req.dev, i_req.addr};
                if (i_req.wr) begin
                    mem[key] = i_req.wdata;
                end
                repeat (i_lat) @(posedge i_sys_clk);
                o_ack <= 1'b1;
                o_rdata <= mem.exists(key) ? mem[key] : 16'h0000;
            end
        end
    end
endmodule

//--- verif/phy_an_regs_bench.sv
`timescale 1ns/1ps
module phy_an_regs_bench;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [15:0] d;
        logic [15:0] x;
    } row_t;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, mack, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] tx_word, mrdata;
    logic [3:0] pstrb, lat;
    phy_an_regs_pkg::an_event_t an;
    phy_an_regs_pkg::mmd_req_t mreq;
    int err_count = 0;
    int samples_checked = 0;
    // Write, address, write data, expected read
    row_t rows [21] = '{
        '{1'b0, 8'h18, 16'h0000, 16'h0064},
        '{1'b0, 8'h1c, 16'h0000, 16'h2001},
        '{1'b0, 8'h20, 16'h0000, 16'h0000},
        '{1'b0, 8'h34, 16'h0000, 16'h0000},
        '{1'b1, 8'h1c, 16'hffff, 16'h0000},
        '{1'b0, 8'h1c, 16'h0000, 16'hb7ff},
        '{1'b1, 8'h20, 16'hffff, 16'h0000},
        '{1'b0, 8'h20, 16'h0000, 16'h0000},
        '{1'b1, 8'h34, 16'h001f, 16'h0000},
        '{1'b0, 8'h34, 16'h0000, 16'h001f},
        '{1'b1, 8'h34, 16'h0003, 16'h0000},
        '{1'b1, 8'h38, 16'h1234, 16'h0000},
        '{1'b0, 8'h38, 16'h0000, 16'h1234},
        '{1'b1, 8'h34, 16'h4003, 16'h0000},
        '{1'b1, 8'h38, 16'hbeef, 16'h0000},
        '{1'b0, 8'h38, 16'h0000, 16'hbeef},
        '{1'b1, 8'h34, 16'h0007, 16'h0000},
        '{1'b1, 8'h34, 16'h4007, 16'h0000},
        '{1'b0, 8'h38, 16'h0000, 16'h0000},
        '{1'b1, 8'h3c, 16'h5555, 16'h0000},
        '{1'b0, 8'h3c, 16'h0000, 16'h0000}
    };
    phy_an_regs i_phy_an_regs (
        .i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_an(an),
        .o_np_tx_word(tx_word), .o_mmd_req(mreq), .i_mmd_ack(mack), .i_mmd_rdata(mrdata)
    );
    mmd_space_model i_mmd_space_model (
        .i_sys_clk(clk), .i_req(mreq), .i_lat(lat), .o_ack(mack), .o_rdata(mrdata)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk_val(input logic [15:0] g, input logic [15:0] x);
        samples_checked++;
        if (g !== x) begin
            err_count++;
            $display("unexpected at %0t: read %h, want %h", $time, g, x);
        end
    endtask
    task automatic chk_flag(input logic g, input logic x);
        samples_checked++;
        if (g !== x) begin
            err_count++;
            $display("unexpected at %0t: error flag %b", $time, g);
        end
    endtask
    // One transfer, held until pready; leaves psel up so calls may chain
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
    endtask
    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        final_report();
    end
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        lat = 4'h2;
        an = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk_val(tx_word, 16'h2001);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk_flag(e, rows[i].a == 8'h3c);
            if (!rows[i].w) begin
                chk_val(r[15:0], rows[i].x);
            end
        end
        idle();
        // Page and fault together; the second read sees the latches cleared
        an.lp_an_able <= 1'b1;
        an.lp_np_able <= 1'b1;
        an.page_word <= 16'hd801;
        an.page_rx <= 1'b1;
        an.pd_fault <= 1'b1;
        @(posedge clk);
        an.page_rx <= 1'b0;
        an.pd_fault <= 1'b0;
        apb(1'b0, 8'h18, 16'h0000);
        chk_val(r[15:0], 16'h007f);
        apb(1'b0, 8'h18, 16'h0000);
        chk_val(r[15:0], 16'h006d);
        apb(1'b0, 8'h20, 16'h0000);
        chk_val(r[15:0], 16'hd801);
        // A lasting fault sets the latch again after each read
        an.pd_fault <= 1'b1;
        idle();
        repeat (2) begin
            apb(1'b0, 8'h18, 16'h0000);
            chk_val(r[15:0], 16'h007d);
        end
        an.pd_fault <= 1'b0;
        an.page_sent <= 1'b1;
        an.sent_toggle <= 1'b1;
        idle();
        an.sent_toggle <= 1'b0;
        idle();
        an.page_sent <= 1'b0;
        apb(1'b0, 8'h1c, 16'h0000);
        chk_val(r[15:0], 16'hbfff);
        // Slow far side stretches the access phase
        lat <= 4'h6;
        apb(1'b1, 8'h38, 16'hcafe);
        apb(1'b0, 8'h38, 16'h0000);
        chk_val(r[15:0], 16'hcafe);
        idle();
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk_val(tx_word, 16'h2001);
        apb(1'b0, 8'h34, 16'h0000);
        chk_val(r[15:0], 16'h0000);
        apb(1'b0, 8'h18, 16'h0000);
        chk_val(r[15:0], 16'h006d);
        // A page arriving with the setup cycle is not reported yet, so it must not be cleared
        an.page_rx <= 1'b1;
        fork
            apb(1'b0, 8'h18, 16'h0000);
            begin
                @(posedge clk);
                an.page_rx <= 1'b0;
            end
        join
        chk_val(r[15:0], 16'h006d);
        apb(1'b0, 8'h18, 16'h0000);
        chk_val(r[15:0], 16'h006f);
        idle();
        final_report();
    end
endmodule
